// [rtl/dcagu_top.sv]
// Dual pointer and coefficient pointer address generator, top level
`timescale 1ns/10ps
module dcagu_top (
  // Clock and reset
  input  wire logic                     i_mclk,
  input  wire logic                     i_reset,
  // Pointer state from the register file
  input  wire logic [22:0]              i_ext_aux_pointer [8],
  input  wire logic [15:0]              i_first_temp_index,
  input  wire logic [15:0]              i_second_temp_index,
  input  wire logic                     i_legacy_compat_bit,
  input  wire logic                     i_control_addr_mode_bit,
  input  wire logic [7:0]               i_pointer_config_status,
  input  wire logic [15:0]              i_buffer_start_pair01,
  input  wire logic [15:0]              i_buffer_start_pair23,
  input  wire logic [15:0]              i_buffer_start_pair45,
  input  wire logic [15:0]              i_buffer_start_pair67,
  // Dual operand requests
  input  wire dcagu_pkg::dcagu_dreq_t   i_first_req,
  input  wire dcagu_pkg::dcagu_dreq_t   i_second_req,
  // Coefficient pointer request
  input  wire logic                     i_coef_valid,
  input  wire dcagu_pkg::dcagu_ckind_t  i_coef_kind,
  input  wire logic [6:0]               i_coefficient_pointer_high,
  input  wire logic [15:0]              i_coefficient_pointer,
  input  wire dcagu_pkg::dcagu_rclass_t i_coef_rclass,
  input  wire dcagu_pkg::dcagu_binst_t  i_coef_binst,
  // Dual operand results
  output dcagu_pkg::dcagu_dres_t        o_first_res,
  output dcagu_pkg::dcagu_dres_t        o_second_res,
  output logic                          o_pointer_conflict,
  // Coefficient results
  output logic                          o_coef_data_valid,
  output logic [22:0]                   o_coef_data_addr,
  output logic [6:0]                    o_coef_page,
  output logic                          o_coef_bit_valid,
  output logic [5:0]                    o_coef_bit_num,
  output logic                          o_coef_bit_error,
  output logic                          o_coef_io_valid,
  output logic [15:0]                   o_coef_io_addr
);
  import dcagu_pkg::*;

  // =====================================================================
  // Shared index selection
  // =====================================================================
  // Compat bit swaps the first index for pointer zero's low word; forms set
  // is the same whatever the control-mode bit says, so it is not decoded.
  wire [15:0] index0 = i_legacy_compat_bit ? i_ext_aux_pointer[0][15:0]
                                           : i_first_temp_index;   // [R11] [R05]
  wire        unused_ctl_mode = i_control_addr_mode_bit;           // [R05]

  function automatic logic [15:0] bsa_of(input logic [2:0] s, input logic [15:0] b01,
                                         input logic [15:0] b23, input logic [15:0] b45,
                                         input logic [15:0] b67);
    case (s[2:1])
      2'h0:    return b01;
      2'h1:    return b23;
      2'h2:    return b45;
      default: return b67;
    endcase
  endfunction

  // =====================================================================
  // Two operand units, one per dual operand
  // =====================================================================
  wire [22:0] a1, a2, n1, n2;
  wire        u1, u2;

  dcagu_operand u_first (                                          // [R03] [R04]
    .i_mode   (i_first_req.mode),
    .i_wide   (i_first_req.wide),
    .i_ptr    (i_ext_aux_pointer[i_first_req.sel]),
    .i_index0 (index0),
    .i_index1 (i_second_temp_index),
    .i_circ   (i_pointer_config_status[i_first_req.sel]),          // [R02] [R07]
    .i_bstart (bsa_of(i_first_req.sel, i_buffer_start_pair01, i_buffer_start_pair23,
                      i_buffer_start_pair45, i_buffer_start_pair67)),
    .o_addr   (a1),
    .o_next   (n1),
    .o_upd    (u1)
  );

  dcagu_operand u_second (                                         // [R03] [R04]
    .i_mode   (i_second_req.mode),
    .i_wide   (i_second_req.wide),
    .i_ptr    (i_ext_aux_pointer[i_second_req.sel]),
    .i_index0 (index0),
    .i_index1 (i_second_temp_index),
    .i_circ   (i_pointer_config_status[i_second_req.sel]),         // [R02] [R07]
    .i_bstart (bsa_of(i_second_req.sel, i_buffer_start_pair01, i_buffer_start_pair23,
                      i_buffer_start_pair45, i_buffer_start_pair67)),
    .o_addr   (a2),
    .o_next   (n2),
    .o_upd    (u2)
  );

  // Flag a stream that modifies one pointer twice; the second update is
  // suppressed so the register file never sees two writers.
  wire conflict = i_first_req.valid & i_second_req.valid &
                  (i_first_req.sel == i_second_req.sel) & u1 & u2;  // [R06]

  // =====================================================================
  // Coefficient pointer decode
  // =====================================================================
  wire [22:0] coef_addr = {i_coefficient_pointer_high, i_coefficient_pointer};  // [R15]
  wire        bit_inst  = (i_coef_binst != DCAGU_BI_OTH);                       // [R18]
  wire        bit_cls   = (i_coef_rclass != DCAGU_RC_OTH);                      // [R18]
  wire [5:0]  bit_msb   = (i_coef_rclass == DCAGU_RC_ACC) ? DCAGU_ACC_MSB
                                                          : DCAGU_REG_MSB;      // [R19]
  wire        bit_range = (i_coefficient_pointer <= {10'h000, bit_msb});        // [R19]
  wire        bit_ok    = bit_inst & bit_cls & bit_range;
  wire        is_bit    = i_coef_valid & (i_coef_kind == DCAGU_CK_BIT);

  // =====================================================================
  // Sequencing: a single generation cycle per request pair
  // =====================================================================
  dcagu_state_t state_q, state_d;
  wire any_req = i_first_req.valid | i_second_req.valid | i_coef_valid;

  always_comb begin
    case (state_q)
      DCAGU_ST_IDLE: state_d = any_req ? DCAGU_ST_GEN : DCAGU_ST_IDLE;
      DCAGU_ST_GEN:  state_d = any_req ? DCAGU_ST_GEN : DCAGU_ST_IDLE;
      default:       state_d = DCAGU_ST_IDLE;
    endcase
  end

  // Both dual results register on the same edge
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q      <= DCAGU_ST_IDLE;
      o_first_res  <= '0;
      o_second_res <= '0;
      o_pointer_conflict <= 1'b0;
    end else begin
      state_q      <= state_d;
      o_first_res  <= '{i_first_req.valid, a1, i_first_req.sel,
                        i_first_req.valid & u1, n1};                       // [R21]
      o_second_res <= '{i_second_req.valid, a2, i_second_req.sel,
                        i_second_req.valid & u2 & ~conflict, n2};          // [R21]
      o_pointer_conflict <= conflict;                                      // [R06]
    end
  end

  // Coefficient outputs register in step with the dual outputs
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_coef_data_valid <= 1'b0;
      o_coef_data_addr  <= DCAGU_ADDR_RST;
      o_coef_page       <= 7'h00;
      o_coef_bit_valid  <= 1'b0;
      o_coef_bit_num    <= 6'h00;
      o_coef_bit_error  <= 1'b0;
      o_coef_io_valid   <= 1'b0;
      o_coef_io_addr    <= 16'h0000;
    end else begin
      o_coef_data_valid <= i_coef_valid & (i_coef_kind == DCAGU_CK_DATA);
      o_coef_data_addr  <= coef_addr;                                      // [R15]
      o_coef_page       <= coef_addr[22:16];                               // [R16]
      o_coef_bit_valid  <= is_bit & bit_ok;                                // [R18]
      o_coef_bit_num    <= i_coefficient_pointer[5:0];                     // [R17]
      o_coef_bit_error  <= is_bit & ~bit_ok;                               // [R19]
      o_coef_io_valid   <= i_coef_valid & (i_coef_kind == DCAGU_CK_IO);
      o_coef_io_addr    <= i_coefficient_pointer;                          // [R20]
    end
  end

  // =====================================================================
  // Checks
  // =====================================================================
  chk_dual_same_cycle: assert property (@(posedge i_mclk) disable iff (i_reset)   // [R21]
    (i_first_req.valid && i_second_req.valid) |=> (o_first_res.valid && o_second_res.valid))
    else $error("dual results not together");
  chk_first_addr_linear: assert property (@(posedge i_mclk) disable iff (i_reset) // [R01]
    (i_first_req.valid && !i_pointer_config_status[i_first_req.sel] &&
     i_first_req.mode == DCAGU_MOD_INC)
    |=> o_first_res.addr == $past(i_ext_aux_pointer[i_first_req.sel]))
    else $error("linear address wrong");
  chk_inc_step: assert property (@(posedge i_mclk) disable iff (i_reset)          // [R09]
    (i_first_req.valid && i_first_req.mode == DCAGU_MOD_INC)
    |=> o_first_res.next == $past(i_ext_aux_pointer[i_first_req.sel])
                            + ($past(i_first_req.wide) ? 23'h2 : 23'h1))
    else $error("increment step wrong");
  chk_dec_step: assert property (@(posedge i_mclk) disable iff (i_reset)          // [R10]
    (i_second_req.valid && i_second_req.mode == DCAGU_MOD_DEC && !i_second_req.wide)
    |=> o_second_res.next == $past(i_ext_aux_pointer[i_second_req.sel]) - 23'h1)
    else $error("decrement step wrong");
  chk_plain_no_upd: assert property (@(posedge i_mclk) disable iff (i_reset)      // [R13]
    (i_first_req.mode == DCAGU_MOD_PLAIN || i_first_req.mode == DCAGU_MOD_OFFX)
    |=> !o_first_res.upd)
    else $error("unmodified form updated");
  chk_conflict_once: assert property (@(posedge i_mclk) disable iff (i_reset)     // [R06]
    o_pointer_conflict |-> !o_second_res.upd)
    else $error("double update on one pointer");
  chk_coef_page: assert property (@(posedge i_mclk) disable iff (i_reset)         // [R16]
    (i_coef_valid && i_coef_kind == DCAGU_CK_DATA)
    |=> o_coef_page == $past(i_coefficient_pointer_high))
    else $error("page field mismatch");
  chk_coef_data_addr: assert property (@(posedge i_mclk) disable iff (i_reset)    // [R15]
    (i_coef_valid && i_coef_kind == DCAGU_CK_DATA)
    |=> o_coef_data_addr == {$past(i_coefficient_pointer_high), $past(i_coefficient_pointer)})
    else $error("coefficient address wrong");
  chk_bit_limit: assert property (@(posedge i_mclk) disable iff (i_reset)         // [R19]
    o_coef_bit_valid |-> $past(i_coefficient_pointer) <=
      (($past(i_coef_rclass) == DCAGU_RC_ACC) ? {10'h000, DCAGU_ACC_MSB}
                                              : {10'h000, DCAGU_REG_MSB}))
    else $error("bit number too high");
  chk_io_addr: assert property (@(posedge i_mclk) disable iff (i_reset)           // [R20]
    (i_coef_valid && i_coef_kind == DCAGU_CK_IO)
    |=> o_coef_io_addr == $past(i_coefficient_pointer))
    else $error("io address wrong");

  cov_dual_pair: cover property (@(posedge i_mclk) o_first_res.valid && o_second_res.valid);
  cov_conflict:  cover property (@(posedge i_mclk) o_pointer_conflict);
  cov_bit_err:   cover property (@(posedge i_mclk) o_coef_bit_error);
  cov_io:        cover property (@(posedge i_mclk) o_coef_io_valid);
endmodule

// [rtl/dcagu_pkg.sv]
// Package for the dual and coefficient pointer address generator
// =====================================================================
// What this block does
// [R01] Each dual operand gets a full 23-bit address from its extended pointer.
// [R02] Each dual operand picks linear or circular addressing on its own.
// [R03] One instruction makes two 16-bit data accesses, first and second operand.
// [R04] Two parallel one-operand instructions map to first and second operand.
// [R05] Dual operand forms do not depend on the control addressing mode bit.
// [R06] Same pointer on both operands only if one leaves it unmodified.
// [R07] Circular pointers add their 16-bit buffer start; linear ones do not.
// [R08] All pointer arithmetic is 23 bits wide, crossing 64K pages freely.
// [R09] Post-increment adds one for 16-bit, two for 32-bit access.
// [R10] Post-decrement subtracts one for 16-bit, two for 32-bit access.
// [R11] Post-add index: sign-extended first index or pointer zero by compat bit.
// [R12] Post-subtract index: same index choice as the add form.
// [R13] Indexed offset and plain forms leave the pointer unchanged.
// [R14] Second-index forms add or subtract sign-extended second temp index.
// [R15] Coefficient data address is high seven bits joined to 16-bit pointer.
// [R16] Upper seven address bits are the main page, 0 to 127.
// [R17] Coefficient register-bit access uses pointer value as bit number, 0 is LSB.
// [R18] Bit access only for test/set/clear/complement on accumulators, pointers, temps.
// [R19] Highest bit is 39 for accumulators, 15 for 16-bit registers.
// [R20] Coefficient I/O access uses the 16-bit pointer as the whole address.
// [R21] Both dual addresses and both pointer updates land in one cycle.
// =====================================================================
package dcagu_pkg;

  localparam int unsigned DCAGU_AW      = 23;
  localparam int unsigned DCAGU_PAGE_W  = 7;
  localparam int unsigned DCAGU_WORD_W  = 16;
  localparam logic [22:0] DCAGU_ADDR_RST = 23'h000000;
  localparam logic [5:0]  DCAGU_ACC_MSB  = 6'h27;   // 39
  localparam logic [5:0]  DCAGU_REG_MSB  = 6'h0F;   // 15
  localparam logic [22:0] DCAGU_STEP_1   = 23'h000001;
  localparam logic [22:0] DCAGU_STEP_2   = 23'h000002;

  // Pointer modification forms of a dual operand
  typedef enum logic [2:0] {
    DCAGU_MOD_PLAIN = 3'h0,
    DCAGU_MOD_INC   = 3'h1,
    DCAGU_MOD_DEC   = 3'h2,
    DCAGU_MOD_ADDX  = 3'h3,
    DCAGU_MOD_SUBX  = 3'h4,
    DCAGU_MOD_OFFX  = 3'h5,
    DCAGU_MOD_ADDT1 = 3'h6,
    DCAGU_MOD_SUBT1 = 3'h7
  } dcagu_mod_t;

  // Coefficient pointer access kinds
  typedef enum logic [1:0] {
    DCAGU_CK_DATA = 2'h0,
    DCAGU_CK_BIT  = 2'h1,
    DCAGU_CK_IO   = 2'h2
  } dcagu_ckind_t;

  // Register classes of a bit access; all but DCAGU_RC_OTH may take one
  typedef enum logic [1:0] {
    DCAGU_RC_ACC  = 2'h0,
    DCAGU_RC_AUX  = 2'h1,
    DCAGU_RC_TMP  = 2'h2,
    DCAGU_RC_OTH  = 2'h3
  } dcagu_rclass_t;

  // Bit-access instruction classes
  typedef enum logic [2:0] {
    DCAGU_BI_TEST = 3'h0,
    DCAGU_BI_SET  = 3'h1,
    DCAGU_BI_CLR  = 3'h2,
    DCAGU_BI_CPL  = 3'h3,
    DCAGU_BI_OTH  = 3'h4
  } dcagu_binst_t;

  // Address generator sequencing state
  typedef enum logic [1:0] {
    DCAGU_ST_IDLE = 2'b00,
    DCAGU_ST_GEN  = 2'b01
  } dcagu_state_t;

  // One dual-operand request
  typedef struct packed {
    logic       valid;
    logic [2:0] sel;
    dcagu_mod_t mode;
    logic       wide;
  } dcagu_dreq_t;

  // One dual-operand result
  typedef struct packed {
    logic        valid;
    logic [22:0] addr;
    logic [2:0]  sel;
    logic        upd;
    logic [22:0] next;
  } dcagu_dres_t;

  // Sign-extend a 16-bit word to the address width
  function automatic logic [22:0] dcagu_sext(input logic [15:0] v);
    return {{7{v[15]}}, v};
  endfunction

endpackage

// [rtl/dcagu_operand.sv]
// One dual-operand address and pointer-update unit
`timescale 1ns/10ps
module dcagu_operand (
  // Request
  input  wire dcagu_pkg::dcagu_mod_t i_mode,
  input  wire logic                  i_wide,
  input  wire logic [22:0]           i_ptr,
  input  wire logic [15:0]           i_index0,
  input  wire logic [15:0]           i_index1,
  input  wire logic                  i_circ,
  input  wire logic [15:0]           i_bstart,
  // Result
  output logic [22:0]                o_addr,
  output logic [22:0]                o_next,
  output logic                       o_upd
);
  import dcagu_pkg::*;

  // =====================================================================
  // Offsets and linear/circular choice
  // =====================================================================
  wire [22:0] step     = i_wide ? DCAGU_STEP_2 : DCAGU_STEP_1;   // [R09] [R10]
  wire [22:0] idx0     = dcagu_sext(i_index0);                   // [R11] [R12]
  wire [22:0] idx1     = dcagu_sext(i_index1);                   // [R14]
  wire [22:0] base_off = i_circ ? {7'h00, i_bstart} : 23'h000000;  // [R07]
  wire [22:0] eff_ptr  = (i_mode == DCAGU_MOD_OFFX) ? i_ptr + idx0 : i_ptr;  // [R13]

  // Address is used before any post-modification
  assign o_addr = eff_ptr + base_off;                            // [R01] [R08]

  // Post-modification, full 23-bit arithmetic wraps over page borders
  always_comb begin
    o_next = i_ptr;
    o_upd  = 1'b1;
    case (i_mode)
      DCAGU_MOD_INC:   o_next = i_ptr + step;                    // [R09]
      DCAGU_MOD_DEC:   o_next = i_ptr - step;                    // [R10]
      DCAGU_MOD_ADDX:  o_next = i_ptr + idx0;                    // [R11]
      DCAGU_MOD_SUBX:  o_next = i_ptr - idx0;                    // [R12]
      DCAGU_MOD_ADDT1: o_next = i_ptr + idx1;                    // [R14]
      DCAGU_MOD_SUBT1: o_next = i_ptr - idx1;                    // [R14]
      default:         o_upd  = 1'b0;                            // [R13]
    endcase
  end
endmodule

// [testbench/dcagu_ptr_file.sv]
// Register-file model that holds the extended pointers and commits their updates
`timescale 1ns/10ps
module dcagu_ptr_file (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  // Preload from the bench
  input  wire logic                   i_load,
  input  wire logic [22:0]            i_load_val [8],
  // Results from the address generator
  input  wire dcagu_pkg::dcagu_dres_t i_first_res,
  input  wire dcagu_pkg::dcagu_dres_t i_second_res,
  // Pointer values seen by the generator
  output logic [22:0]                 o_ptr [8]
);
  import dcagu_pkg::*;
  // ==========================================================================
  // Commit
  // Preload wins over commits so that every bench case starts from clean pointers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      for (int k = 0; k < 8; k++) o_ptr[k] <= DCAGU_ADDR_RST;
    end else if (i_load) begin
      o_ptr <= i_load_val;
    end else begin
      // Both updates land on one edge, first then second
      if (i_first_res.valid && i_first_res.upd) begin
        o_ptr[i_first_res.sel] <= i_first_res.next;
      end
      if (i_second_res.valid && i_second_res.upd) begin
        o_ptr[i_second_res.sel] <= i_second_res.next;
      end
    end
  end
endmodule

// [testbench/dcagu_top_tb_top.sv]
// Self-checking bench for the dual and coefficient pointer address generator
`timescale 1ns/10ps
module dcagu_top_tb_top;
  import dcagu_pkg::*;
  // ==========================================================================
  // Signals
  typedef struct packed {
    logic [2:0]  sel;
    logic [2:0]  mode;
    logic        wide;
    logic        cmp;
    logic [7:0]  cfg;
    logic [22:0] p;
    logic [22:0] a;
    logic [22:0] n;
    logic        u;
  } dcagu_row_t;
  logic          clk, rst, load, compat, ctl, cv, ok;
  logic [22:0]   ptr [8];
  logic [22:0]   lv [8];
  logic [15:0]   ti0, ti1, b01, b23, b45, b67, cp;
  logic [15:0]   lims [5];
  logic [7:0]    cfg;
  logic [6:0]    ch;
  dcagu_dreq_t   fq, sq;
  dcagu_ckind_t  ck;
  dcagu_rclass_t rc;
  dcagu_binst_t  bi;
  dcagu_dres_t   fr, sr;
  logic          conf, cdv, cbv, cbe, civ;
  logic [22:0]   cda;
  logic [6:0]    cpg;
  logic [5:0]    cbn;
  logic [15:0]   cia;
  int            err_total, checks;
  // First index is -2, second index is -32768, pointer zero low word is -1
  dcagu_row_t rows [15] = '{
    '{3'h1, 3'h0, 1'b0, 1'b0, 8'h00, 23'h00ABCD, 23'h00ABCD, 23'h000000, 1'b0},
    '{3'h1, 3'h1, 1'b0, 1'b0, 8'h00, 23'h00FFFF, 23'h00FFFF, 23'h010000, 1'b1},
    '{3'h2, 3'h1, 1'b1, 1'b0, 8'h00, 23'h010000, 23'h010000, 23'h010002, 1'b1},
    '{3'h3, 3'h2, 1'b0, 1'b0, 8'h00, 23'h010000, 23'h010000, 23'h00FFFF, 1'b1},
    '{3'h3, 3'h2, 1'b1, 1'b0, 8'h00, 23'h000005, 23'h000005, 23'h000003, 1'b1},
    '{3'h4, 3'h3, 1'b0, 1'b0, 8'h00, 23'h000010, 23'h000010, 23'h00000E, 1'b1},
    '{3'h4, 3'h3, 1'b0, 1'b1, 8'h00, 23'h000010, 23'h000010, 23'h00000F, 1'b1},
    '{3'h5, 3'h4, 1'b0, 1'b0, 8'h00, 23'h000010, 23'h000010, 23'h000012, 1'b1},
    '{3'h5, 3'h4, 1'b0, 1'b1, 8'h00, 23'h000010, 23'h000010, 23'h000011, 1'b1},
    '{3'h6, 3'h5, 1'b0, 1'b0, 8'h00, 23'h020000, 23'h01FFFE, 23'h000000, 1'b0},
    '{3'h6, 3'h5, 1'b0, 1'b1, 8'h00, 23'h020000, 23'h01FFFF, 23'h000000, 1'b0},
    '{3'h2, 3'h6, 1'b0, 1'b0, 8'h00, 23'h010000, 23'h010000, 23'h008000, 1'b1},
    '{3'h2, 3'h7, 1'b0, 1'b0, 8'h00, 23'h010000, 23'h010000, 23'h018000, 1'b1},
    '{3'h1, 3'h1, 1'b0, 1'b0, 8'h02, 23'h000020, 23'h000120, 23'h000021, 1'b1},
    '{3'h6, 3'h5, 1'b0, 1'b0, 8'h40, 23'h020000, 23'h0207FE, 23'h000000, 1'b0}};
  // ==========================================================================
  // Design and partner
  dcagu_top DUT (.i_mclk(clk), .i_reset(rst), .i_ext_aux_pointer(ptr),
    .i_first_temp_index(ti0), .i_second_temp_index(ti1), .i_legacy_compat_bit(compat),
    .i_control_addr_mode_bit(ctl), .i_pointer_config_status(cfg),
    .i_buffer_start_pair01(b01), .i_buffer_start_pair23(b23),
    .i_buffer_start_pair45(b45), .i_buffer_start_pair67(b67),
    .i_first_req(fq), .i_second_req(sq), .i_coef_valid(cv), .i_coef_kind(ck),
    .i_coefficient_pointer_high(ch), .i_coefficient_pointer(cp), .i_coef_rclass(rc),
    .i_coef_binst(bi), .o_first_res(fr), .o_second_res(sr), .o_pointer_conflict(conf),
    .o_coef_data_valid(cdv), .o_coef_data_addr(cda), .o_coef_page(cpg),
    .o_coef_bit_valid(cbv), .o_coef_bit_num(cbn), .o_coef_bit_error(cbe),
    .o_coef_io_valid(civ), .o_coef_io_addr(cia));
  dcagu_ptr_file u_ptr (.i_mclk(clk), .i_reset(rst), .i_load(load), .i_load_val(lv),
    .i_first_res(fr), .i_second_res(sr), .o_ptr(ptr));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [22:0] seen, input logic [22:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Results are registered, so one edge then a settled look at the falling edge
  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50us;
    err_total++;
    end_of_test();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    err_total = 0; checks = 0; rst = 1'b1; load = 1'b0; compat = 1'b0; ctl = 1'b0;
    ti0 = 16'hFFFE; ti1 = 16'h8000; b01 = 16'h0100; b23 = 16'h0200; b45 = 16'h0400;
    b67 = 16'h0800; cfg = 8'h00; fq = '0; sq = '0; cv = 1'b0; ck = DCAGU_CK_DATA;
    ch = 7'h00; cp = 16'h0000; rc = DCAGU_RC_ACC; bi = DCAGU_BI_TEST; ok = 1'b0;
    lims = '{16'h000F, 16'h0010, 16'h0027, 16'h0028, 16'h0100};
    lv = '{default: 23'h000000};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    step();
    chk(23'({fr.valid, sr.valid, conf, cdv, cbv, cbe, civ}), 23'h000000);
    $display("reset test done");
    // Table pass twice, with the control addressing bit clear then set
    for (int m = 0; m < 2; m++) begin
      ctl = m[0];
      foreach (rows[i]) begin
        lv = '{default: 23'h000000};
        lv[0] = 23'h03FFFF;
        lv[7] = 23'h023456;
        lv[rows[i].sel] = rows[i].p;
        load = 1'b1;
        step();
        load = 1'b0; compat = rows[i].cmp; cfg = rows[i].cfg;
        fq = '{1'b1, rows[i].sel, dcagu_mod_t'(rows[i].mode), rows[i].wide};
        sq = '{1'b1, 3'h7, DCAGU_MOD_INC, 1'b0};
        step();
        fq.valid = 1'b0; sq.valid = 1'b0;
        chk(23'({fr.valid, fr.sel, fr.upd}), 23'({1'b1, rows[i].sel, rows[i].u}));
        chk(fr.addr, rows[i].a);
        if (rows[i].u) chk(fr.next, rows[i].n);
        chk(sr.addr, 23'h023456);
        chk(sr.next, 23'h023457);
        chk(23'({sr.valid, sr.sel, sr.upd}), 23'({1'b1, 3'h7, 1'b1}));
      end
    end
    $display("operand table test done");
    // Same pointer modified by both operands, then shared with one plain use
    lv[3] = 23'h000100;
    load = 1'b1;
    step();
    load = 1'b0; cfg = 8'h00;
    fq = '{1'b1, 3'h3, DCAGU_MOD_INC, 1'b0};
    sq = '{1'b1, 3'h3, DCAGU_MOD_DEC, 1'b0};
    step();
    sq.mode = DCAGU_MOD_PLAIN;
    chk(23'({conf, sr.upd, fr.upd}), 23'h000005);
    chk(fr.next, 23'h000101);
    step();
    fq.valid = 1'b0; sq.valid = 1'b0;
    chk(23'({conf, sr.upd}), 23'h000000);
    chk(sr.addr, 23'h000100);
    $display("pointer sharing test done");
    // Coefficient data at the top of the last page, then I/O
    cv = 1'b1; ck = DCAGU_CK_DATA; ch = 7'h7F; cp = 16'hFFFF;
    step();
    chk(cda, 23'h7FFFFF);
    chk(23'({cdv, cpg, civ, cbv}), 23'({1'b1, 7'h7F, 2'b00}));
    ck = DCAGU_CK_IO; cp = 16'hBEEF;
    step();
    chk(23'({civ, cdv, cia}), 23'({2'b10, 16'hBEEF}));
    // Every instruction and register class against bit limits
    ck = DCAGU_CK_BIT;
    for (int b = 0; b < 5; b++) begin
      for (int c = 0; c < 4; c++) begin
        for (int n = 0; n < 5; n++) begin
          bi = dcagu_binst_t'(b); rc = dcagu_rclass_t'(c); cp = lims[n];
          ok = (b < 4) && (c < 3) && (cp <= ((c == 0) ? 16'h0027 : 16'h000F));
          step();
          chk(23'({cbv, cbe}), 23'({ok, !ok}));
          if (ok) chk(23'(cbn), 23'(cp[5:0]));
        end
      end
    end
    cv = 1'b0;
    $display("coefficient test done");
    end_of_test();
  end
endmodule
